/* File: verilog/pmas_pkg.sv */
// Purpose: shared constants and types for the pre-add multiply slice
// Assumes: single clock, all data two's complement
// Notes: operand selector encodings and field positions live here
//
// Contract
// RL1 - port a feeds multiplier or post-adder per low two select bits
// RL2 - port c is used only by the post-adder path
// RL3 - port d is the second pre-adder input beside b
// RL4 - p gives the 48-bit result; one carry-out bit for a neighbour
// RL5 - each register group has its own active-high clear
// RL6 - one slice-wide setting makes all clears synchronous or asynchronous; the acc_r accumulator clear is always synchronous
// RL7 - each register group has its own enable; loads only while high
// RL8 - outside logic ties unused clears low, enables per register presence
// RL9 - product chain input comes from upstream slice or is zero
// RL10 - operand chain input is an alternative source for b
// RL11 - product chain output feeds the next slice; may float
// RL12 - operand chain output feeds next slice b; may float
// RL13 - eight-bit operation select may change every cycle
// RL14 - select bits 1:0 pick x: zero, product, p, or d-a-b concat
// RL15 - select bits 3:2 pick z: zero, product chain, p, or c
// RL16 - select bit 4 low bypasses pre-adder, high uses b-d result
// RL17 - select bit 5 gives carry-in only when carry source chooses it
// RL18 - select bit 6: pre-adder adds when low, subtracts when high
// RL19 - select bit 7: post-adder adds when low, subtracts when high
// RL20 - external carry in comes only from another slice carry-out
// RL21 - x plus carry first, then added to or subtracted from z
// RL22 - concat is d[11:0] high, then a, then b low
// RL23 - 36-bit product sign-extends to 48 bits before post-adder
// RL24 - a and b allow 0-2 stages; others 0 or 1
// RL25 - fixed choice of b from parallel port or operand chain
package pmas_pkg;
    localparam int OPND_W = 18;
    localparam int WIDE_W = 48;
    localparam int PROD_W = 36;
    localparam int OPS_W = 8;
    localparam int CAT_D_W = 12;
    localparam int OPS_X_LSB = 0;
    localparam int OPS_Z_LSB = 2;
    localparam int OPS_PRE_USE = 4;
    localparam int OPS_CIN = 5;
    localparam int OPS_PRE_SUB = 6;
    localparam int OPS_POST_SUB = 7;
    localparam logic [1:0] X_ZERO = 2'h0;
    localparam logic [1:0] X_PROD = 2'h1;
    localparam logic [1:0] X_ACC = 2'h2;
    localparam logic [1:0] X_CAT = 2'h3;
    localparam logic [1:0] Z_ZERO = 2'h0;
    localparam logic [1:0] Z_CHAIN = 2'h1;
    localparam logic [1:0] Z_ACC = 2'h2;
    localparam logic [1:0] Z_C = 2'h3;
    localparam int CLR_SYNC = 0;
    localparam int CLR_ASYNC = 1;
    localparam int CIN_FROM_EXT = 0;
    localparam int CIN_FROM_OPSEL = 1;
    localparam int B_FROM_PORT = 0;
    localparam int B_FROM_CHAIN = 1;
    localparam int STAGE_MAX_AB = 2;
    localparam int STAGE_MAX = 1;

    typedef struct packed {
        logic [WIDE_W-1:0] x;
        logic [WIDE_W-1:0] z;
        logic cin;
        logic sub;
    } pmas_post_t;
endpackage

/* File: verilog/pmas_pipe.sv */
// Purpose: optional pipeline stage with group clear and group enable
// Assumes: rst is the global asynchronous reset
// Notes: absent stage passes d straight through
`timescale 1ns/10ps
module pmas_pipe #(
    parameter int W = 18,
    parameter bit PRESENT = 1'b1,
    parameter bit ASYNC_CLR = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] q_r;

    generate
        if (!PRESENT) begin : g_bypass
            assign q_r = '0;
            assign q = d;
        end else if (ASYNC_CLR) begin : g_async
            // group clear acts without the clock
            always_ff @(posedge clk or posedge rst or posedge clr) begin
                if (rst || clr) begin
                    q_r <= '0;
                end else if (en) begin
                    q_r <= d;
                end
            end
            assign q = q_r;
        end else begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    q_r <= '0;
                end else if (clr) begin
                    q_r <= '0;
                end else if (en) begin
                    q_r <= d;
                end
            end
            assign q = q_r;
        end
    endgenerate
endmodule // pmas_pipe

/* File: verilog/pmas_slice.sv */
// Purpose: pre-adder, 18x18 multiplier and 48-bit post-adder slice
// Assumes: all inputs synchronous to clk; configuration fixed
// Notes: p feedback always comes from the internal accumulator register
`timescale 1ns/10ps
module pmas_slice #(
    parameter int unsigned a_first_pipe_cfg = 0,
    parameter int unsigned a_second_pipe_cfg = 1,
    parameter int unsigned b_first_pipe_cfg = 0,
    parameter int unsigned b_second_pipe_cfg = 1,
    parameter int unsigned c_pipe_cfg = 1,
    parameter int unsigned d_pipe_cfg = 1,
    parameter int unsigned mult_pipe_cfg = 1,
    parameter int unsigned out_pipe_cfg = 1,
    parameter int unsigned carry_pipe_cfg = 1,
    parameter int unsigned opsel_pipe_cfg = 1,
    parameter int unsigned clear_style_cfg = 0,
    parameter int unsigned carry_source_cfg = 0,
    parameter int unsigned b_source_cfg = 0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [17:0] a_in,
    input wire logic [17:0] b_in,
    input wire logic [47:0] c_in,
    input wire logic [17:0] d_in,
    input wire logic [7:0] op_select,
    input wire logic carry_in_ext,
    input wire logic [47:0] product_chain_in,
    input wire logic [17:0] operand_chain_in,
    input wire logic clr_a_regs,
    input wire logic clr_b_regs,
    input wire logic clr_c_regs,
    input wire logic clr_d_regs,
    input wire logic clr_mult_regs,
    input wire logic clr_out_regs,
    input wire logic clr_carry_reg,
    input wire logic clr_opsel_reg,
    input wire logic en_a_regs,
    input wire logic en_b_regs,
    input wire logic en_c_regs,
    input wire logic en_d_regs,
    input wire logic en_mult_regs,
    input wire logic en_out_regs,
    input wire logic en_carry_reg,
    input wire logic en_opsel_reg,
    output logic [47:0] p_out,
    output logic carry_out_ext,
    output logic [47:0] product_chain_out,
    output logic [17:0] operand_chain_out
);
    localparam int OW = pmas_pkg::OPND_W;
    localparam int WW = pmas_pkg::WIDE_W;
    localparam int PW = pmas_pkg::PROD_W;
    localparam bit ACLR = (clear_style_cfg == pmas_pkg::CLR_ASYNC); // RL6

    // refuse stage counts the structure cannot build
    generate
        if (a_first_pipe_cfg > 1 || a_second_pipe_cfg > 1 ||
            b_first_pipe_cfg > 1 || b_second_pipe_cfg > 1) begin : g_bad_ab
            $error("a/b stage settings must be 0 or 1 each");
        end
        if (c_pipe_cfg > pmas_pkg::STAGE_MAX ||
            d_pipe_cfg > pmas_pkg::STAGE_MAX ||
            mult_pipe_cfg > pmas_pkg::STAGE_MAX ||
            out_pipe_cfg > pmas_pkg::STAGE_MAX ||
            carry_pipe_cfg > pmas_pkg::STAGE_MAX ||
            opsel_pipe_cfg > pmas_pkg::STAGE_MAX) begin : g_bad_stage
            $error("single-stage settings must be 0 or 1");
        end
        if (clear_style_cfg > 1 || carry_source_cfg > 1 ||
            b_source_cfg > 1) begin : g_bad_sel
            $error("selection settings must be 0 or 1");
        end
    endgenerate

    logic [OW-1:0] a_mid;
    logic [OW-1:0] a_q;
    logic [OW-1:0] b_src;
    logic [OW-1:0] b_mid;
    logic [OW-1:0] b_q;
    logic [OW-1:0] d_q;
    logic [WW-1:0] c_q;
    logic [7:0] ops;
    logic [OW-1:0] pre_sum;
    logic [OW-1:0] mult_b;
    logic [PW-1:0] prod_raw;
    logic [PW-1:0] prod_q;
    logic [WW-1:0] prod_ext;
    logic [WW-1:0] cat_opnd;
    logic [1:0] x_sel;
    logic [1:0] z_sel;
    logic cin_src;
    logic cin_q;
    pmas_pkg::pmas_post_t post;
    logic [WW:0] x_plus_c;
    logic [WW:0] post_res;
    logic [WW:0] acc_r;
    logic [WW:0] out_q;

    // operand b source fixed by configuration
    assign b_src = (b_source_cfg == pmas_pkg::B_FROM_CHAIN) ?
        operand_chain_in : b_in; // RL25 RL10

    // a path: up to two stages
    pmas_pipe #(.W(OW), .PRESENT(a_first_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_a0 (
        .clk(clk),
        .rst(rst),
        .clr(clr_a_regs),
        .en(en_a_regs),
        .d(a_in),
        .q(a_mid)
    ); // RL24 RL5 RL7

    pmas_pipe #(.W(OW), .PRESENT(a_second_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_a1 (
        .clk(clk),
        .rst(rst),
        .clr(clr_a_regs),
        .en(en_a_regs),
        .d(a_mid),
        .q(a_q)
    ); // RL24

    // b path: up to two stages
    pmas_pipe #(.W(OW), .PRESENT(b_first_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_b0 (
        .clk(clk),
        .rst(rst),
        .clr(clr_b_regs),
        .en(en_b_regs),
        .d(b_src),
        .q(b_mid)
    ); // RL24 RL5 RL7

    pmas_pipe #(.W(OW), .PRESENT(b_second_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_b1 (
        .clk(clk),
        .rst(rst),
        .clr(clr_b_regs),
        .en(en_b_regs),
        .d(b_mid),
        .q(b_q)
    ); // RL24

    pmas_pipe #(.W(OW), .PRESENT(d_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_d (
        .clk(clk),
        .rst(rst),
        .clr(clr_d_regs),
        .en(en_d_regs),
        .d(d_in),
        .q(d_q)
    ); // RL3 RL5 RL7

    pmas_pipe #(.W(WW), .PRESENT(c_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_c (
        .clk(clk),
        .rst(rst),
        .clr(clr_c_regs),
        .en(en_c_regs),
        .d(c_in),
        .q(c_q)
    ); // RL2 RL5 RL7

    pmas_pipe #(.W(8), .PRESENT(opsel_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_ops (
        .clk(clk),
        .rst(rst),
        .clr(clr_opsel_reg),
        .en(en_opsel_reg),
        .d(op_select),
        .q(ops)
    ); // RL13 RL5 RL7

    // pre-adder: d plus or minus b, wraps at 18 bits
    assign pre_sum = ops[pmas_pkg::OPS_PRE_SUB] ?
        d_q - b_q : d_q + b_q; // RL18 RL3
    assign mult_b = ops[pmas_pkg::OPS_PRE_USE] ? pre_sum : b_q; // RL16
    assign prod_raw = PW'($signed(a_q) * $signed(mult_b)); // RL1

    pmas_pipe #(.W(PW), .PRESENT(mult_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_m (
        .clk(clk),
        .rst(rst),
        .clr(clr_mult_regs),
        .en(en_mult_regs),
        .d(prod_raw),
        .q(prod_q)
    ); // RL5 RL7

    assign prod_ext = {{(WW - PW){prod_q[PW-1]}}, prod_q}; // RL23
    assign cat_opnd = {d_q[pmas_pkg::CAT_D_W-1:0], a_q, b_q}; // RL22

    // carry source chosen once by configuration
    assign cin_src = (carry_source_cfg == pmas_pkg::CIN_FROM_OPSEL) ?
        op_select[pmas_pkg::OPS_CIN] : carry_in_ext; // RL17 RL20

    pmas_pipe #(.W(1), .PRESENT(carry_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_cin (
        .clk(clk),
        .rst(rst),
        .clr(clr_carry_reg),
        .en(en_carry_reg),
        .d(cin_src),
        .q(cin_q)
    ); // RL5 RL7

    // x and z selectors
    assign x_sel = ops[pmas_pkg::OPS_X_LSB +: 2];
    assign z_sel = ops[pmas_pkg::OPS_Z_LSB +: 2];

    always_comb begin
        unique case (x_sel) // RL14 RL1
            pmas_pkg::X_ZERO: post.x = '0;
            pmas_pkg::X_PROD: post.x = prod_ext;
            pmas_pkg::X_ACC: post.x = acc_r[WW-1:0];
            pmas_pkg::X_CAT: post.x = cat_opnd;
        endcase
        unique case (z_sel) // RL15
            pmas_pkg::Z_ZERO: post.z = '0;
            pmas_pkg::Z_CHAIN: post.z = product_chain_in;
            pmas_pkg::Z_ACC: post.z = acc_r[WW-1:0];
            pmas_pkg::Z_C: post.z = c_q;
        endcase
        post.cin = cin_q;
        post.sub = ops[pmas_pkg::OPS_POST_SUB];
    end

    // post-adder: z plus or minus (x + carry); top bit is carry/borrow
    assign x_plus_c = {1'b0, post.x} + {{WW{1'b0}}, post.cin}; // RL21
    assign post_res = post.sub ? {1'b0, post.z} - x_plus_c :
        {1'b0, post.z} + x_plus_c; // RL19 RL21

    // accumulator always registered so feedback never loops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= '0;
        end else if (clr_out_regs) begin
            acc_r <= '0;
        end else if (en_out_regs) begin
            acc_r <= post_res;
        end
    end // RL5 RL7

    pmas_pipe #(.W(WW + 1), .PRESENT(out_pipe_cfg == 1), .ASYNC_CLR(ACLR))
    u_p (
        .clk(clk),
        .rst(rst),
        .clr(clr_out_regs),
        .en(en_out_regs),
        .d(post_res),
        .q(out_q)
    ); // RL4 RL5 RL7

    assign p_out = out_q[WW-1:0]; // RL4
    assign carry_out_ext = out_q[WW]; // RL4
    assign product_chain_out = out_q[WW-1:0]; // RL11
    assign operand_chain_out = b_q; // RL12

    // checks
    x_zero_sel_a: assert property (@(posedge clk) disable iff (rst)
        x_sel == pmas_pkg::X_ZERO |-> post.x == '0)
        else $error("x not zero when selected"); // RL14

    x_prod_sel_a: assert property (@(posedge clk) disable iff (rst)
        x_sel == pmas_pkg::X_PROD |->
        post.x == {{12{prod_q[35]}}, prod_q})
        else $error("x not sign-extended product"); // RL23

    x_cat_sel_a: assert property (@(posedge clk) disable iff (rst)
        x_sel == pmas_pkg::X_CAT |-> post.x[47:36] == d_q[11:0] &&
        post.x[35:18] == a_q && post.x[17:0] == b_q)
        else $error("concat operand order wrong"); // RL22

    z_src_sel_a: assert property (@(posedge clk) disable iff (rst)
        (z_sel == pmas_pkg::Z_C |-> post.z == c_q) and
        (z_sel == pmas_pkg::Z_CHAIN |-> post.z == product_chain_in))
        else $error("z selector source wrong"); // RL15

    pre_add_sub_a: assert property (@(posedge clk) disable iff (rst)
        ops[4] |-> mult_b == (ops[6] ? 18'(d_q - b_q) : 18'(d_q + b_q)))
        else $error("pre-adder result wrong"); // RL18

    pre_bypass_a: assert property (@(posedge clk) disable iff (rst)
        !ops[4] |-> mult_b == b_q)
        else $error("pre-adder not bypassed"); // RL16

    post_dir_a: assert property (@(posedge clk) disable iff (rst)
        post_res[47:0] == (ops[7] ?
        48'(post.z - post.x - {47'h0, cin_q}) :
        48'(post.z + post.x + {47'h0, cin_q})))
        else $error("post-adder result wrong"); // RL19

    acc_load_a: assert property (@(posedge clk) disable iff (rst)
        en_out_regs && !clr_out_regs |=> acc_r == $past(post_res))
        else $error("accumulator did not load"); // RL7

    acc_hold_a: assert property (@(posedge clk) disable iff (rst)
        !en_out_regs && !clr_out_regs |=> $stable(acc_r))
        else $error("accumulator changed while disabled"); // RL7

    acc_clear_a: assert property (@(posedge clk) disable iff (rst)
        clr_out_regs |=> acc_r == '0)
        else $error("accumulator not cleared"); // RL5

    carry_src_a: assert property (@(posedge clk) disable iff (rst)
        carry_pipe_cfg == 1 && en_carry_reg && !clr_carry_reg |=>
        cin_q == (carry_source_cfg == 1 ? $past(op_select[5]) :
        $past(carry_in_ext)) || (ACLR && clr_carry_reg))
        else $error("carry-in not from chosen source"); // RL17

    carry_raw_a: assert property (@(posedge clk) disable iff (rst)
        carry_pipe_cfg == 0 && carry_source_cfg == 1 |->
        cin_q == op_select[5])
        else $error("unregistered carry-in not from select bit"); // RL17

    acc_feed_a: assert property (@(posedge clk) disable iff (rst)
        en_out_regs && !clr_out_regs ##1 x_sel == pmas_pkg::X_ACC |->
        post.x == $past(post_res[47:0]))
        else $error("accumulate feedback wrong"); // RL14

    z_fill_sel_a: assert property (@(posedge clk) disable iff (rst)
        (z_sel == pmas_pkg::Z_ZERO |-> post.z == '0) and
        (z_sel == pmas_pkg::Z_ACC |-> post.z == acc_r[WW-1:0]))
        else $error("z zero or feedback wrong"); // RL15

    // an asynchronous clear may land between the two edges
    p_load_a: assert property (@(posedge clk) disable iff (rst)
        out_pipe_cfg == 1 && en_out_regs && !clr_out_regs |=>
        {carry_out_ext, p_out} == $past(post_res) ||
        (ACLR && clr_out_regs))
        else $error("output register did not load"); // RL4

    p_clear_a: assert property (@(posedge clk) disable iff (rst)
        out_pipe_cfg == 1 && clr_out_regs |=> p_out == '0 && !carry_out_ext)
        else $error("output register not cleared"); // RL5

    b_chain_out_a: assert property (@(posedge clk) disable iff (rst)
        b_second_pipe_cfg == 1 && en_b_regs && !clr_b_regs |=>
        operand_chain_out == $past(b_mid) || (ACLR && clr_b_regs))
        else $error("operand chain output did not load"); // RL12

    opsel_hold_a: assert property (@(posedge clk) disable iff (rst)
        opsel_pipe_cfg == 1 && !en_opsel_reg && !clr_opsel_reg |=>
        $stable(ops) || (ACLR && clr_opsel_reg))
        else $error("operation select changed while disabled"); // RL7
endmodule // pmas_slice

/* File: tb/pmas_fabric_model.sv */
// Purpose: stand-in for fabric and upstream slice feeding the chain inputs
// Assumes: same clock as the slice under test
// Notes: an unused product chain reads as zeros
`timescale 1ns/10ps
module pmas_fabric_model (
    input wire logic clk,
    input wire logic chain_en,
    input wire logic [47:0] up_value,
    input wire logic up_carry,
    input wire logic [17:0] up_operand,
    output logic [47:0] product_chain_in,
    output logic carry_in_ext,
    output logic [17:0] operand_chain_in
);
    initial begin
        product_chain_in = 48'h0;
        carry_in_ext = 1'h0;
        operand_chain_in = 18'h0;
    end
    // outputs move just after the edge, as a registered upstream slice would
    always @(posedge clk) begin
        product_chain_in <= chain_en ? up_value : 48'h0;
        carry_in_ext <= chain_en & up_carry;
        operand_chain_in <= up_operand;
    end
endmodule // pmas_fabric_model

/* File: tb/pmas_slice_test.sv */
// Purpose: self-checking bench for the pre-add multiply slice
// Assumes: two builds share stimulus; the second has deep a/b, async clears
// Notes: the second build takes b from the operand chain, carry from bit 5
`timescale 1ns/10ps
module pmas_slice_test;
    typedef struct packed {
        logic [7:0] op;
        logic [17:0] a;
        logic [17:0] b;
        logic [17:0] d;
        logic [47:0] c;
        logic [47:0] ch;
        logic ci;
    } pmas_row_t;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [17:0] a_in = 18'h0, b_in = 18'h0, d_in = 18'h0;
    logic [17:0] up_operand = 18'h0;
    logic [47:0] c_in = 48'h0, up_value = 48'h0;
    logic [7:0] op_select = 8'h0;
    logic chain_en = 1'h0, up_carry = 1'h0;
    logic clr_a_regs, clr_b_regs, clr_c_regs, clr_d_regs;
    logic clr_mult_regs, clr_out_regs, clr_carry_reg, clr_opsel_reg;
    logic en_a_regs, en_b_regs, en_c_regs, en_d_regs;
    logic en_mult_regs, en_out_regs, en_carry_reg, en_opsel_reg;
    logic [47:0] product_chain_in, p_out, product_chain_out, p2, pc2;
    logic [17:0] operand_chain_in, operand_chain_out, bo2;
    logic carry_in_ext, carry_out_ext, co2;
    int failures = 0, check_count = 0, cycles = 0;
    pmas_row_t rows [8];
    logic [48:0] e;
    logic [47:0] v;

    always #12.5 clk = ~clk;

    pmas_fabric_model u_pmas_fabric_model (.*);
    pmas_slice u_pmas_slice (.*);
    pmas_slice #(.a_first_pipe_cfg(1), .b_first_pipe_cfg(1), .c_pipe_cfg(0),
        .d_pipe_cfg(0), .mult_pipe_cfg(0), .out_pipe_cfg(0),
        .carry_pipe_cfg(0), .opsel_pipe_cfg(0), .clear_style_cfg(1),
        .carry_source_cfg(1), .b_source_cfg(1)) u_pmas_slice_chained (.*,
        .p_out(p2), .carry_out_ext(co2), .product_chain_out(pc2),
        .operand_chain_out(bo2));

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic set_en(input logic [7:0] m);
        {en_a_regs, en_b_regs, en_c_regs, en_d_regs, en_mult_regs,
            en_out_regs, en_carry_reg, en_opsel_reg} <= m;
    endtask

    task automatic set_clr(input logic [7:0] m);
        {clr_a_regs, clr_b_regs, clr_c_regs, clr_d_regs, clr_mult_regs,
            clr_out_regs, clr_carry_reg, clr_opsel_reg} <= m;
    endtask

    // bit 48 of the result is the carry or borrow bit
    function automatic logic [48:0] ref_p(input logic [7:0] op,
        input logic [17:0] a, b, d, input logic [47:0] c, ch,
        input logic ci);
        logic [17:0] pre;
        logic [35:0] prod;
        logic [47:0] x, z;
        logic [48:0] xc;
        pre = op[4] ? (op[6] ? d - b : d + b) : b;
        prod = $signed(a) * $signed(pre);
        case (op[1:0])
            pmas_pkg::X_PROD: x = {{12{prod[35]}}, prod};
            pmas_pkg::X_CAT: x = {d[11:0], a, b};
            default: x = 48'h0;
        endcase
        case (op[3:2])
            pmas_pkg::Z_CHAIN: z = ch;
            pmas_pkg::Z_C: z = c;
            default: z = 48'h0;
        endcase
        xc = {1'h0, x} + {48'h0, ci};
        ref_p = op[7] ? {1'h0, z} - xc : {1'h0, z} + xc;
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            $display("ERROR %0t: run took too long", $time);
            end_sim();
        end
    end

    initial begin
        set_en(8'hFF);
        set_clr(8'h00);
        rows[0] = '{8'h05, 18'h3, 18'h3FFFE, 18'h0, 48'h0, 48'h64, 1'h1};
        rows[1] = '{8'h0D, 18'h1FFFF, 18'h1FFFF, 18'h0, 48'h100, 48'h0, 1'h0};
        rows[2] = '{8'h17, 18'h12345, 18'h0ABCD, 18'h3FABC, 48'h0,
            48'h10000000, 1'h0};
        rows[3] = '{8'h91, 18'h5, 18'h7, 18'h9, 48'h0, 48'h0, 1'h1};
        rows[4] = '{8'hD1, 18'h5, 18'h7, 18'h3, 48'h0, 48'h0, 1'h0};
        rows[5] = '{8'h3F, 18'h1, 18'h2, 18'h0, 48'hFFFFFFFFFFFF, 48'h0, 1'h1};
        rows[6] = '{8'h8D, 18'h3FFFF, 18'h10, 18'h0, 48'h5, 48'h0, 1'h1};
        rows[7] = '{8'h50, 18'h4, 18'h6, 18'h1, 48'h0, 48'h0, 1'h1};
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        chk(p_out, 48'h0);
        chk(operand_chain_out, 48'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge clk);
            op_select <= rows[i].op;
            a_in <= rows[i].a;
            b_in <= rows[i].b;
            up_operand <= rows[i].b + 18'h1;
            d_in <= rows[i].d;
            c_in <= rows[i].c;
            chain_en <= 1'h1;
            up_value <= rows[i].ch;
            up_carry <= rows[i].ci;
            repeat (5) @(posedge clk);
            @(negedge clk);
            e = ref_p(rows[i].op, rows[i].a, rows[i].b, rows[i].d, rows[i].c,
                rows[i].ch, rows[i].ci);
            chk(p_out, e[47:0]);
            chk(carry_out_ext, e[48]);
            chk(product_chain_out, e[47:0]);
            chk(operand_chain_out, rows[i].b);
            e = ref_p(rows[i].op, rows[i].a, rows[i].b + 18'h1, rows[i].d,
                rows[i].c, rows[i].ch, rows[i].op[5]);
            chk(p2, e[47:0]);
            chk(co2, e[48]);
            chk(pc2, e[47:0]);
            chk(bo2, 18'(rows[i].b + 18'h1));
        end
        $display("test table done");
        @(posedge clk);
        op_select <= 8'h09;
        a_in <= 18'h3;
        b_in <= 18'h5;
        up_operand <= 18'h5;
        chain_en <= 1'h0;
        set_clr(8'h04);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(p_out, 48'h0);
        @(posedge clk);
        set_clr(8'h00);
        v = 48'h0;
        repeat (3) begin
            @(negedge clk);
            chk(p_out, v);
            v = v + 48'hF;
        end
        @(posedge clk);
        set_en(8'hFB);
        repeat (2) begin
            @(negedge clk);
            chk(p_out, v);
        end
        $display("test accumulate and hold done");
        @(posedge clk);
        set_en(8'hFF);
        op_select <= 8'h02;
        chain_en <= 1'h1;
        up_carry <= 1'h1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        v = p_out;
        repeat (2) begin
            @(negedge clk);
            v = v + 48'h1;
            chk(p_out, v);
        end
        $display("test x feedback done");
        @(posedge clk);
        op_select <= 8'h0C;
        c_in <= 48'h1234;
        chain_en <= 1'h0;
        repeat (3) @(posedge clk);
        set_clr(8'h20);
        @(negedge clk);
        chk(p_out, 48'h1234);
        repeat (2) @(negedge clk);
        chk(p_out, 48'h0);
        chk(operand_chain_out, 48'h5);
        chk(p2, 48'h1234);
        $display("test group clear done");
        @(posedge clk);
        set_clr(8'h00);
        op_select <= 8'h01;
        a_in <= 18'h7;
        up_operand <= 18'h2;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(p2, 48'hE);
        @(posedge clk);
        set_clr(8'h80);
        #1;
        chk(p2, 48'h0);
        chk(p_out, 48'h23);
        @(posedge clk);
        set_clr(8'h00);
        $display("test async clear done");
        @(posedge clk);
        set_clr(8'hFF);
        op_select <= 8'h0D;
        c_in <= 48'h40;
        @(posedge clk);
        @(negedge clk);
        chk(p_out, 48'h0);
        chk(carry_out_ext, 48'h0);
        chk(operand_chain_out, 48'h0);
        chk(p2, 48'h40);
        @(posedge clk);
        set_clr(8'h00);
        set_en(8'h00);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(p_out, 48'h0);
        chk(operand_chain_out, 48'h0);
        chk(p2, 48'h40);
        @(posedge clk);
        set_en(8'hFF);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(p_out, 48'h63);
        $display("test all groups done");
        end_sim();
    end
endmodule // pmas_slice_test
